/* File: dmst_pkg.sv */
// How it works
// - mode codes: 1 open-loop, 2 induction flux, 3 servo flux, 4 regen
// - mode writes refused unless unlock code holds 1253 or 1254
// - drive reset applying a new mode loads defaults, then saves them
// - level 0: all writable parameters editable, basic menu only visible
// - level 1: all menus visible and editable
// - level 2: everything read-only from the keypad (comms may still write), basic menu only visible
// - level 3: everything read-only from the keypad (comms may still write), all menus visible
// - level 4: keypad stays in status, no viewing or editing
// - keypad may always write the security level
// - firmware version is read-only, 0 to 99999999
// - trip action word is five independent bits, reset to zero
// - bit 0: stop before tripping on the non-important trip causes
// - bit 1: braking resistor overload detection disabled
// - bit 2: phase loss keeps running, trips once the user stops
// - bit 3: brake resistor temperature monitoring and its trip disabled
// - bit 4: parameter freeze on trip disabled
// - bit 4 clear: monitored values frozen from trip until trip clear
package dmst_pkg;
  localparam logic [7:0] IDX_MODE = 8'h30;
  localparam logic [7:0] IDX_SEC = 8'h31;
  localparam logic [7:0] IDX_FW = 8'h32;
  localparam logic [7:0] IDX_TRIP = 8'h33;
  localparam logic [2:0] MODE_OPEN = 3'h1;
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_SERVO = 3'h3;
  localparam logic [2:0] MODE_REGEN = 3'h4;
  localparam logic [2:0] MODE_RST = MODE_OPEN;
  localparam logic [15:0] UNLOCK_EU = 16'h04E5;
  localparam logic [15:0] UNLOCK_US = 16'h04E6;
  localparam logic [2:0] SEC_MENU0 = 3'h0;
  localparam logic [2:0] SEC_ALL = 3'h1;
  localparam logic [2:0] SEC_RO_MENU0 = 3'h2;
  localparam logic [2:0] SEC_RO = 3'h3;
  localparam logic [2:0] SEC_STATUS = 3'h4;
  localparam logic [2:0] SEC_NONE = 3'h5;
  localparam logic [2:0] SEC_RST = SEC_MENU0;
  localparam int TRIP_W = 5;
  localparam logic [4:0] TRIP_RST = 5'h00;
  localparam int TB_STOP = 0;
  localparam int TB_BRK_OVL = 1;
  localparam int TB_PHASE = 2;
  localparam int TB_BRK_TEMP = 3;
  localparam int TB_FREEZE = 4;
  localparam logic [31:0] FW_MAX = 32'h05F5E0FF;
endpackage

/* File: dmst_trip_if.sv */
`timescale 1ns/10ps
interface dmst_trip_if;
  logic [4:0] cfg;
  logic io_ovl;
  logic ain1_loss;
  logic ain2_loss;
  logic kp_mode_trip;
  logic brk_ovl;
  logic phase_loss;
  logic brk_therm_open;
  logic running;
  logic trip_clear;
  logic trip;
  logic stop_req;
  logic freeze;
  modport ctrl (input cfg, io_ovl, ain1_loss, ain2_loss, kp_mode_trip,
    brk_ovl, phase_loss, brk_therm_open, running, trip_clear,
    output trip, stop_req, freeze);
  modport bank (output cfg, io_ovl, ain1_loss, ain2_loss, kp_mode_trip,
    brk_ovl, phase_loss, brk_therm_open, running, trip_clear,
    input trip, stop_req, freeze);
endinterface

/* File: dmst_sec_gate.sv */
`timescale 1ns/10ps
module dmst_sec_gate
  import dmst_pkg::*;
(
  input wire logic [2:0] level,
  input wire logic from_keypad,
  input wire logic wr,
  input wire logic [7:0] idx,
  output logic allow
);
  // all parameters of this bank sit in the basic menu
  always_comb
  begin
    allow = 1'b1;
    if (from_keypad)
    begin
      case (level)
        SEC_MENU0: allow = 1'b1;
        SEC_ALL: allow = 1'b1;
        SEC_RO_MENU0: allow = !wr;
        SEC_RO: allow = !wr;
        default: allow = 1'b0;
      endcase
      if (wr && idx == IDX_SEC)
        allow = 1'b1;
    end
    else if (level == SEC_NONE)
      allow = 1'b0;
  end
endmodule

/* File: dmst_trip_ctrl.sv */
`timescale 1ns/10ps
module dmst_trip_ctrl
  import dmst_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  dmst_trip_if.ctrl t
);
  logic noncrit;
  logic trip_set;
  logic trip_reg;
  logic stop_req_reg;
  logic freeze_reg;
  logic pl_pend_reg;

  assign noncrit = t.io_ovl | t.ain1_loss | t.ain2_loss | t.kp_mode_trip;

  always_comb
  begin
    trip_set = 1'b0;
    if (noncrit && (!t.cfg[TB_STOP] || !t.running))
      trip_set = 1'b1;
    if (t.brk_ovl && !t.cfg[TB_BRK_OVL])
      trip_set = 1'b1;
    if (t.phase_loss && !t.cfg[TB_PHASE])
      trip_set = 1'b1;
    if (pl_pend_reg && !t.running)
      trip_set = 1'b1;
    if (t.brk_therm_open && !t.cfg[TB_BRK_TEMP])
      trip_set = 1'b1;
  end

  // phase loss seen while running waits for the user stop
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pl_pend_reg <= 1'b0;
    else if (t.phase_loss && t.cfg[TB_PHASE])
      pl_pend_reg <= 1'b1;
    else if (trip_reg)
      pl_pend_reg <= 1'b0;
  end

  // a new cause wins over a clear in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      trip_reg <= 1'b0;
    else if (trip_set)
      trip_reg <= 1'b1;
    else if (t.trip_clear)
      trip_reg <= 1'b0;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      stop_req_reg <= 1'b0;
    else
      stop_req_reg <= (noncrit & t.cfg[TB_STOP]) |
        (t.phase_loss & ~t.cfg[TB_PHASE]);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      freeze_reg <= 1'b0;
    else if (t.cfg[TB_FREEZE])
      freeze_reg <= 1'b0;
    else if (trip_set)
      freeze_reg <= 1'b1;
    else if (t.trip_clear)
      freeze_reg <= 1'b0;
  end

  assign t.trip = trip_reg;
  assign t.stop_req = stop_req_reg;
  assign t.freeze = freeze_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  brk_therm_trip_a: assert property (
    t.brk_therm_open && !t.cfg[TB_BRK_TEMP] |=> t.trip)
    else $error("thermistor open did not trip");
  stop_first_a: assert property (noncrit && t.cfg[TB_STOP]
    |=> t.stop_req) else $error("no stop before trip");
  freeze_hold_a: assert property (t.freeze && !t.trip_clear
    && !t.cfg[TB_FREEZE] |=> t.freeze) else $error("freeze lost");
  freeze_off_a: assert property (t.cfg[TB_FREEZE]
    |=> !t.freeze) else $error("freeze while disabled");
endmodule

/* File: dmst_param_bank.sv */
`timescale 1ns/10ps
module dmst_param_bank
  import dmst_pkg::*;
#(
  parameter logic [31:0] FW_VERSION = 32'h00000000
)
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic kp_req,
  input wire logic kp_wr,
  input wire logic [7:0] kp_idx,
  input wire logic [31:0] kp_wdata,
  output logic kp_ack,
  output logic kp_err,
  output logic [31:0] kp_rdata,
  input wire logic cm_req,
  input wire logic cm_wr,
  input wire logic [7:0] cm_idx,
  input wire logic [31:0] cm_wdata,
  output logic cm_ack,
  output logic cm_err,
  output logic [31:0] cm_rdata,
  input wire logic [15:0] unlock_code_parameter,
  input wire logic drive_reset,
  output logic [2:0] act_mode,
  output logic defaults_load,
  output logic nv_save,
  output logic kp_view_all,
  output logic kp_status_only,
  output logic [4:0] trip_action,
  input wire logic io_ovl,
  input wire logic ain1_loss,
  input wire logic ain2_loss,
  input wire logic kp_mode_trip,
  input wire logic brk_ovl,
  input wire logic phase_loss,
  input wire logic brk_therm_open,
  input wire logic motor_running,
  input wire logic trip_clear,
  output logic trip_out,
  output logic stop_req,
  output logic freeze_hold
);
  typedef enum logic [1:0] {MS_IDLE, MS_LOAD, MS_SAVE} dmst_apply_t;

  // firmware word, clipped to the displayable range (value is arbitrary)
  localparam logic [31:0] FW_WORD =
    (FW_VERSION > FW_MAX) ? FW_MAX : FW_VERSION;

  logic [2:0] par_mode_reg;
  logic [2:0] act_mode_reg;
  logic [2:0] sec_reg;
  logic [4:0] trip_cfg_reg;
  dmst_apply_t apply_reg;
  logic defaults_load_reg;
  logic nv_save_reg;
  logic kp_view_all_reg;
  logic kp_status_only_reg;
  logic kp_ack_reg;
  logic kp_err_reg;
  logic [31:0] kp_rdata_reg;
  logic cm_ack_reg;
  logic cm_err_reg;
  logic [31:0] cm_rdata_reg;

  logic kp_take;
  logic cm_take;
  logic sel_kp;
  logic sel_wr;
  logic [7:0] sel_idx;
  logic [31:0] sel_wdata;
  logic kp_allow;
  logic cm_allow;
  logic sel_allow;
  logic unlocked;
  logic [32:0] rd_word;
  logic wr_ok;
  logic acc_ok;
  logic do_write;

  dmst_trip_if trip_bus ();

  // read decode: bit 32 marks a mapped parameter
  function automatic logic [32:0] read_word(
    input logic [7:0] idx,
    input logic [2:0] mode,
    input logic [2:0] sec,
    input logic [4:0] cfg
  );
    logic [32:0] r;
    r = {1'b0, 32'h00000000};
    case (idx)
      IDX_MODE: r = {1'b1, 29'h00000000, mode};
      IDX_SEC: r = {1'b1, 29'h00000000, sec};
      IDX_FW: r = {1'b1, FW_WORD};
      IDX_TRIP: r = {1'b1, 27'h0000000, cfg};
      default: r = {1'b0, 32'h00000000};
    endcase
    return r;
  endfunction

  // write check: mapped, writable and in range
  function automatic logic write_ok(
    input logic [7:0] idx,
    input logic [31:0] wdata,
    input logic unl
  );
    logic ok;
    ok = 1'b0;
    case (idx)
      IDX_MODE: ok = unl && wdata >= 32'(MODE_OPEN)
        && wdata <= 32'(MODE_REGEN);
      IDX_SEC: ok = wdata <= 32'(SEC_NONE);
      IDX_TRIP: ok = wdata < 32'h00000020;
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  // requests are levels held until ack; keypad wins a collision
  assign kp_take = kp_req & ~kp_ack_reg;
  assign cm_take = cm_req & ~cm_ack_reg & ~kp_take;
  assign sel_kp = kp_take;
  assign sel_wr = sel_kp ? kp_wr : cm_wr;
  assign sel_idx = sel_kp ? kp_idx : cm_idx;
  assign sel_wdata = sel_kp ? kp_wdata : cm_wdata;

  assign unlocked = (unlock_code_parameter == UNLOCK_EU) ||
    (unlock_code_parameter == UNLOCK_US);

  dmst_sec_gate kp_gate (
    .level(sec_reg),
    .from_keypad(1'b1),
    .wr(kp_wr),
    .idx(kp_idx),
    .allow(kp_allow)
  );

  dmst_sec_gate cm_gate (
    .level(sec_reg),
    .from_keypad(1'b0),
    .wr(cm_wr),
    .idx(cm_idx),
    .allow(cm_allow)
  );

  assign sel_allow = sel_kp ? kp_allow : cm_allow;
  assign rd_word = read_word(sel_idx, par_mode_reg, sec_reg, trip_cfg_reg);
  assign wr_ok = write_ok(sel_idx, sel_wdata, unlocked);
  assign acc_ok = sel_allow && (sel_wr ? wr_ok : rd_word[32]);
  assign do_write = (kp_take | cm_take) & sel_wr & acc_ok;

  // mode parameter; takes effect only at the next drive reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      par_mode_reg <= MODE_RST;
    else if (do_write && sel_idx == IDX_MODE)
      par_mode_reg <= sel_wdata[2:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      sec_reg <= SEC_RST;
    else if (do_write && sel_idx == IDX_SEC)
      sec_reg <= sel_wdata[2:0];
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      trip_cfg_reg <= TRIP_RST;
    else if (apply_reg == MS_LOAD)
      trip_cfg_reg <= TRIP_RST;
    else if (do_write && sel_idx == IDX_TRIP)
      trip_cfg_reg <= sel_wdata[TRIP_W-1:0];
  end

  // mode change sequence: apply, load defaults, save to nonvolatile memory
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      apply_reg <= MS_IDLE;
      act_mode_reg <= MODE_RST;
      defaults_load_reg <= 1'b0;
      nv_save_reg <= 1'b0;
    end
    else
    begin
      defaults_load_reg <= 1'b0;
      nv_save_reg <= 1'b0;
      case (apply_reg)
        MS_IDLE:
        begin
          if (drive_reset && par_mode_reg != act_mode_reg)
          begin
            act_mode_reg <= par_mode_reg;
            defaults_load_reg <= 1'b1;
            apply_reg <= MS_LOAD;
          end
        end
        MS_LOAD:
        begin
          nv_save_reg <= 1'b1;
          apply_reg <= MS_SAVE;
        end
        MS_SAVE: apply_reg <= MS_IDLE;
        default: apply_reg <= MS_IDLE;
      endcase
    end
  end

  // keypad display control from the security level
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      kp_view_all_reg <= 1'b0;
      kp_status_only_reg <= 1'b0;
    end
    else
    begin
      kp_view_all_reg <= (sec_reg == SEC_ALL) || (sec_reg == SEC_RO);
      kp_status_only_reg <= (sec_reg == SEC_STATUS) ||
        (sec_reg == SEC_NONE);
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      kp_ack_reg <= 1'b0;
      kp_err_reg <= 1'b0;
      kp_rdata_reg <= 32'h00000000;
    end
    else
    begin
      kp_ack_reg <= kp_take;
      if (kp_take)
      begin
        kp_err_reg <= !acc_ok;
        kp_rdata_reg <= (acc_ok && !kp_wr) ? rd_word[31:0] : 32'h00000000;
      end
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cm_ack_reg <= 1'b0;
      cm_err_reg <= 1'b0;
      cm_rdata_reg <= 32'h00000000;
    end
    else
    begin
      cm_ack_reg <= cm_take;
      if (cm_take)
      begin
        cm_err_reg <= !acc_ok;
        cm_rdata_reg <= (acc_ok && !cm_wr) ? rd_word[31:0] : 32'h00000000;
      end
    end
  end

  assign trip_bus.cfg = trip_cfg_reg;
  assign trip_bus.io_ovl = io_ovl;
  assign trip_bus.ain1_loss = ain1_loss;
  assign trip_bus.ain2_loss = ain2_loss;
  assign trip_bus.kp_mode_trip = kp_mode_trip;
  assign trip_bus.brk_ovl = brk_ovl;
  assign trip_bus.phase_loss = phase_loss;
  assign trip_bus.brk_therm_open = brk_therm_open;
  assign trip_bus.running = motor_running;
  assign trip_bus.trip_clear = trip_clear;

  dmst_trip_ctrl trip_ctrl (
    .clk(clk),
    .sys_rst(sys_rst),
    .t(trip_bus)
  );

  assign kp_ack = kp_ack_reg;
  assign kp_err = kp_err_reg;
  assign kp_rdata = kp_rdata_reg;
  assign cm_ack = cm_ack_reg;
  assign cm_err = cm_err_reg;
  assign cm_rdata = cm_rdata_reg;
  assign act_mode = act_mode_reg;
  assign defaults_load = defaults_load_reg;
  assign nv_save = nv_save_reg;
  assign kp_view_all = kp_view_all_reg;
  assign kp_status_only = kp_status_only_reg;
  assign trip_action = trip_cfg_reg;
  assign trip_out = trip_bus.trip;
  assign stop_req = trip_bus.stop_req;
  assign freeze_hold = trip_bus.freeze;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence mode_change_s;
    apply_reg == MS_IDLE && drive_reset && par_mode_reg != act_mode_reg;
  endsequence

  sequence load_then_save_s;
    defaults_load_reg && !nv_save_reg ##1 nv_save_reg && !defaults_load_reg;
  endsequence

  mode_apply_seq_a: assert property (mode_change_s |=> load_then_save_s)
    else $error("mode change without load and save");
  mode_applied_a: assert property (mode_change_s
    |=> act_mode_reg == $past(par_mode_reg))
    else $error("new mode not applied");
  trip_default_a: assert property (apply_reg == MS_LOAD
    |=> trip_cfg_reg == TRIP_RST)
    else $error("trip word not defaulted");
  mode_locked_a: assert property ((kp_take || cm_take) && sel_wr
    && sel_idx == IDX_MODE && !unlocked |=> $stable(par_mode_reg))
    else $error("mode changed while locked");
  mode_code_a: assert property (par_mode_reg >= MODE_OPEN
    && par_mode_reg <= MODE_REGEN)
    else $error("mode code out of range");
  kp_status_lock_a: assert property (kp_take && sec_reg >= SEC_STATUS
    && !(kp_wr && kp_idx == IDX_SEC) |=> kp_ack && kp_err)
    else $error("keypad access at status level");
  kp_sec_write_a: assert property (kp_take && kp_wr
    && kp_idx == IDX_SEC && kp_wdata <= 32'(SEC_NONE)
    |=> !kp_err && sec_reg == $past(kp_wdata[2:0]))
    else $error("keypad security write refused");
  cm_no_access_a: assert property (cm_take && sec_reg == SEC_NONE
    |=> cm_ack && cm_err) else $error("comms access at level 5");
  // the default load of a mode change may overwrite the word that cycle
  kp_read_only_a: assert property (kp_take && kp_wr && kp_idx != IDX_SEC
    && (sec_reg == SEC_RO_MENU0 || sec_reg == SEC_RO)
    && apply_reg != MS_LOAD |=> kp_err && $stable(trip_cfg_reg))
    else $error("write at read-only level");
  fw_read_a: assert property (kp_take && !kp_wr && kp_idx == IDX_FW
    && sec_reg <= SEC_RO |=> kp_rdata == FW_WORD && kp_rdata <= FW_MAX)
    else $error("firmware word wrong");
endmodule

/* File: dmst_host_model.sv */
`timescale 1ns/10ps
module dmst_host_model
(
  input wire logic clk,
  output logic req,
  output logic wr,
  output logic [7:0] idx,
  output logic [31:0] wdata,
  input wire logic ack,
  input wire logic err,
  input wire logic [31:0] rdata
);
  initial
  begin
    req = 1'b0;
    wr = 1'b0;
    idx = 8'h00;
    wdata = 32'h0;
  end
  // one request held until ack is sampled; hung set if no answer
  task automatic xfer(input logic w, input logic [7:0] i,
    input logic [31:0] d, output logic e, output logic [31:0] q,
    output logic hung);
    int n;
    n = 0;
    hung = 1'b1;
    e = 1'b1;
    q = 32'h0;
    @(negedge clk);
    req = 1'b1;
    wr = w;
    idx = i;
    wdata = d;
    while (n < 20 && hung === 1'b1)
    begin
      @(posedge clk);
      n++;
      if (ack === 1'b1)
      begin
        hung = 1'b0;
        e = err;
        q = rdata;
      end
    end
    @(negedge clk);
    req = 1'b0;
    // released lines carry the inverse, never a stale value
    wr = ~wr;
    idx = ~idx;
    wdata = ~wdata;
  endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/10ps
module testbench;
  import dmst_pkg::*;
  // arbitrary version word within range
  localparam logic [31:0] FW = 32'h00BC614E;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic kp_req, kp_wr, kp_ack, kp_err, cm_req, cm_wr, cm_ack, cm_err;
  logic [7:0] kp_idx, cm_idx;
  logic [31:0] kp_wdata, kp_rdata, cm_wdata, cm_rdata;
  logic [15:0] unlock = 16'h0;
  logic drive_reset = 1'b0;
  logic [2:0] act_mode;
  logic defaults_load, nv_save, kp_view_all, kp_status_only;
  logic [4:0] trip_action;
  logic [6:0] cause = 7'h00;
  logic motor_running = 1'b0;
  logic trip_clear = 1'b0;
  logic trip_out, stop_req, freeze_hold;
  int bad_count = 0;
  int compares = 0;
  always #2 clk = ~clk;
  dmst_param_bank #(.FW_VERSION(FW)) i_dmst_param_bank (.clk(clk),
    .sys_rst(sys_rst), .kp_req(kp_req), .kp_wr(kp_wr), .kp_idx(kp_idx),
    .kp_wdata(kp_wdata), .kp_ack(kp_ack), .kp_err(kp_err),
    .kp_rdata(kp_rdata), .cm_req(cm_req), .cm_wr(cm_wr), .cm_idx(cm_idx),
    .cm_wdata(cm_wdata), .cm_ack(cm_ack), .cm_err(cm_err),
    .cm_rdata(cm_rdata), .unlock_code_parameter(unlock),
    .drive_reset(drive_reset), .act_mode(act_mode),
    .defaults_load(defaults_load), .nv_save(nv_save),
    .kp_view_all(kp_view_all), .kp_status_only(kp_status_only),
    .trip_action(trip_action), .io_ovl(cause[0]), .ain1_loss(cause[1]),
    .ain2_loss(cause[2]), .kp_mode_trip(cause[3]), .brk_ovl(cause[4]),
    .phase_loss(cause[5]), .brk_therm_open(cause[6]),
    .motor_running(motor_running), .trip_clear(trip_clear),
    .trip_out(trip_out), .stop_req(stop_req), .freeze_hold(freeze_hold));
  dmst_host_model i_kp_host (.clk(clk), .req(kp_req), .wr(kp_wr),
    .idx(kp_idx), .wdata(kp_wdata), .ack(kp_ack), .err(kp_err),
    .rdata(kp_rdata));
  dmst_host_model i_cm_host (.clk(clk), .req(cm_req), .wr(cm_wr),
    .idx(cm_idx), .wdata(cm_wdata), .ack(cm_ack), .err(cm_err),
    .rdata(cm_rdata));
  task automatic finish_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // p selects comms; refused or write answers carry zero data
  task automatic acc(input bit p, input logic w, input logic [7:0] i,
    input logic [31:0] d, input logic ee, input logic [31:0] qe);
    logic e;
    logic [31:0] q;
    logic hung;
    if (p)
      i_cm_host.xfer(w, i, d, e, q, hung);
    else
      i_kp_host.xfer(w, i, d, e, q, hung);
    if (hung === 1'b1)
    begin
      bad_count++;
      finish_test();
    end
    check(32'(e), 32'(ee));
    check(q, qe);
  endtask
  task automatic t_reset();
    check(32'(act_mode), 32'(MODE_RST));
    acc(0, 0, IDX_MODE, 32'h0, 0, 32'(MODE_RST));
    acc(0, 0, IDX_SEC, 32'h0, 0, 32'(SEC_RST));
    acc(1, 0, IDX_TRIP, 32'h0, 0, 32'(TRIP_RST));
    acc(0, 0, IDX_FW, 32'h0, 0, FW);
    acc(1, 1, IDX_FW, 32'h1, 1, 32'h0);
    acc(1, 0, 8'h34, 32'h0, 1, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_mode();
    logic [2:0] m [4];
    logic [2:0] prev;
    m = '{MODE_IND, MODE_SERVO, MODE_REGEN, MODE_OPEN};
    prev = MODE_RST;
    acc(0, 1, IDX_MODE, 32'h2, 1, 32'h0);
    acc(0, 0, IDX_MODE, 32'h0, 0, 32'(MODE_RST));
    for (int k = 0; k < 4; k++)
    begin
      unlock = k[0] ? UNLOCK_US : UNLOCK_EU;
      acc(0, 1, IDX_MODE, 32'h5, 1, 32'h0);
      acc(0, 1, IDX_TRIP, 32'h5, 0, 32'h0);
      acc(0, 1, IDX_MODE, 32'(m[k]), 0, 32'h0);
      acc(1, 0, IDX_MODE, 32'h0, 0, 32'(m[k]));
      check(32'(act_mode), 32'(prev));
      drive_reset = 1'b1;
      @(negedge clk);
      drive_reset = 1'b0;
      check(32'(act_mode), 32'(m[k]));
      check({act_mode, defaults_load, nv_save}, {m[k], 2'h2});
      @(negedge clk);
      check({trip_action, defaults_load, nv_save}, 7'h01);
      prev = m[k];
    end
    repeat (2) @(negedge clk);
    drive_reset = 1'b1;
    @(negedge clk);
    drive_reset = 1'b0;
    check(32'(defaults_load), 32'h0);
    $display("test mode done");
  endtask
  task automatic t_sec();
    for (int lv = 0; lv < 6; lv++)
    begin
      acc(0, 1, IDX_SEC, 32'(lv), 0, 32'h0);
      check(32'(kp_view_all), 32'(lv == 1 || lv == 3));
      check(32'(kp_status_only), 32'(lv >= 4));
      acc(0, 1, IDX_TRIP, 32'h1, lv >= 2, 32'h0);
      acc(0, 0, IDX_TRIP, 32'h0, lv >= 4, 32'(lv < 4));
      acc(1, 1, IDX_TRIP, 32'h1, lv == 5, 32'h0);
      acc(1, 0, IDX_TRIP, 32'h0, lv == 5, 32'(lv < 5));
    end
    acc(0, 1, IDX_SEC, 32'h6, 1, 32'h0);
    acc(0, 1, IDX_SEC, 32'h0, 0, 32'h0);
    $display("test security done");
  endtask
  // cause held while running, then motor stopped, then trip cleared
  task automatic tc(input logic [4:0] cfg, input int c, input logic t1,
    input logic s1, input logic f1, input logic t2);
    acc(0, 1, IDX_TRIP, 32'(cfg), 0, 32'h0);
    check(32'(trip_action), 32'(cfg));
    motor_running = 1'b1;
    cause = 7'(1 << c);
    repeat (2) @(negedge clk);
    check({trip_out, stop_req, freeze_hold}, {t1, s1, f1});
    motor_running = 1'b0;
    repeat (2) @(negedge clk);
    check(32'(trip_out), 32'(t2));
    cause = 7'h00;
    trip_clear = 1'b1;
    repeat (2) @(negedge clk);
    trip_clear = 1'b0;
    @(negedge clk);
    check({trip_out, freeze_hold}, 2'h0);
  endtask
  task automatic t_trip();
    for (int c = 0; c < 4; c++)
    begin
      tc(5'h00, c, 1, 0, 1, 1);
      tc(5'h01, c, 0, 1, 0, 1);
    end
    tc(5'h00, 4, 1, 0, 1, 1);
    tc(5'h02, 4, 0, 0, 0, 0);
    tc(5'h00, 5, 1, 1, 1, 1);
    tc(5'h04, 5, 0, 0, 0, 1);
    tc(5'h00, 6, 1, 0, 1, 1);
    tc(5'h08, 6, 0, 0, 0, 0);
    tc(5'h10, 4, 1, 0, 0, 1);
    // a cause present while clearing keeps trip and freeze set
    acc(0, 1, IDX_TRIP, 32'h0, 0, 32'h0);
    cause = 7'h01;
    trip_clear = 1'b1;
    repeat (2) @(negedge clk);
    check({trip_out, freeze_hold}, 2'h3);
    cause = 7'h00;
    @(negedge clk);
    trip_clear = 1'b0;
    check({trip_out, freeze_hold}, 2'h0);
    $display("test trip done");
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    t_reset();
    t_mode();
    t_sec();
    t_trip();
    finish_test();
  end
endmodule
